// >>> tcdi_map.svh
// What this block does
// - forced remote defect bit set sends bit 8 of tandem frame 73 as one
// - forced outgoing defect bit set sends bit 7 of tandem frame 74 as one
// - tandem ais bit set drives bit 4 of the outgoing N2 byte high
// - feature disabled suppresses every receive tandem alarm of that port
// - feature disabled sends N2 bits 3 to 8 as zero, BIP-2 kept
// - feature and auto remote enable send remote defect on listed alarms
// - drop ais, h4 error, unequipped, j2 lock loss need their qualify bits
// - auto remote enable off: remote defect only from the forced bit
// - defect indications go out once per 38 ms tandem multiframe
// - alarms sampled every 500 us multiframe and latched until used
// - auto outgoing enable sends outgoing defect on the same alarms
//
// Purpose: offsets, fields and timing for the tandem defect inserter
// Assumes: 40 MHz clock, Wishbone word index = register offset
// Notes: one 8-bit control register and one 8-bit config register per port
`ifndef TCDI_MAP_SVH
`define TCDI_MAP_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define TCDI_CTRL_P1 8'h51
`define TCDI_CTRL_P2 8'h81
`define TCDI_CTRL_P3 8'hB1
`define TCDI_CTRL_P4 8'hE1
`define TCDI_CFG_P1 8'h53
`define TCDI_CFG_P2 8'h83
`define TCDI_CFG_P3 8'hB3
`define TCDI_CFG_P4 8'hE3
`define TCDI_STAT_P1 8'h54
`define TCDI_STAT_P2 8'h84
`define TCDI_STAT_P3 8'hB4
`define TCDI_STAT_P4 8'hE4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TCDI_B_FRC_RDI 7
`define TCDI_B_FRC_ODI 6
`define TCDI_B_TC_AIS 5
`define TCDI_B_TC_EN 4
`define TCDI_B_AUTO_RDI 3
`define TCDI_B_AUTO_ODI 2
`define TCDI_CTRL_RESET 8'h00

// ----------------------------------------
// config register fields
// ----------------------------------------
`define TCDI_B_SIZE 0
`define TCDI_B_DAIS_Q 1
`define TCDI_B_H4_Q 2
`define TCDI_B_UNEQ_Q 3
`define TCDI_B_J2_Q 4
`define TCDI_CFG_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define TCDI_CLK_KHZ 40000
`define TCDI_MF_US 500
`define TCDI_MF_CYC ((`TCDI_MF_US * `TCDI_CLK_KHZ) / 1000)
`define TCDI_TCMF_MS 38
`define TCDI_TCMF_MFS ((`TCDI_TCMF_MS * 1000) / `TCDI_MF_US)

`endif

// >>> tcdi_pkg.sv
// Purpose: shared types for the tandem defect inserter
// Assumes: four ports
// Notes: none
package tcdi_pkg;
	typedef logic [7:0] tcdi_byte_t;
	typedef logic [10:0] tcdi_alarm_t;
endpackage

// >>> tcdi_div.sv
// Purpose: one-cycle enable every CYCLES clocks that have en_i high
// Assumes: synchronous reset
// Notes: pulse marks end of each period
`timescale 1ns/1ps
`default_nettype none
module tcdi_div #(
	parameter int CYCLES = 20000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	output logic tick_o
);
	typedef struct packed {
		logic [31:0] cnt;
	} tcdi_div_st_t;
	tcdi_div_st_t s_r;
	tcdi_div_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		tick_o = 1'b0;
		if (en_i) begin
			if (s_r.cnt == 32'(CYCLES - 1)) begin
				s_nxt.cnt = 32'h0;
				tick_o = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> tcdi_port.sv
// Purpose: per-port tandem overhead and defect latching
// Assumes: alarm inputs already synchronous to clk_i
// Notes: alarm bits: 0 lop,1 tu ais,2 drop ais,3 h4,4 uneq,5 slm,
//        6 j2 lol,7 j2 tim,8 tc uneq,9 tc lol,10 tc lom
`timescale 1ns/1ps
`include "tcdi_map.svh"
`default_nettype none
module tcdi_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tcdi_pkg::tcdi_byte_t ctrl_i,
	input wire tcdi_pkg::tcdi_byte_t cfg_i,
	input wire tcdi_pkg::tcdi_alarm_t alarm_i,
	input wire logic mf_tick_i,
	input wire logic tcmf_tick_i,
	input wire logic [1:0] bip2_i,
	output logic [7:0] n2_o,
	output logic rdi_bit_o,
	output logic odi_bit_o,
	output logic rx_tc_alarm_en_o,
	output logic [1:0] latch_o
);
	import tcdi_pkg::*;

	typedef struct packed {
		logic lat;
		logic rdi;
		logic odi;
		logic [7:0] n2;
	} tcdi_port_st_t;
	tcdi_port_st_t s_r;
	tcdi_port_st_t s_nxt;
	logic en;
	logic any_alarm;
	logic rdi_now;
	logic odi_now;

	always_comb begin
		en = ctrl_i[`TCDI_B_TC_EN];
		// qualified alarms only count when their enable is set
		any_alarm = alarm_i[0] | alarm_i[1] | alarm_i[5] | alarm_i[7] |
			alarm_i[8] | alarm_i[9] | alarm_i[10] |
			(alarm_i[2] & cfg_i[`TCDI_B_DAIS_Q]) |
			(alarm_i[3] & cfg_i[`TCDI_B_H4_Q]) |
			(alarm_i[4] & cfg_i[`TCDI_B_UNEQ_Q]) |
			(alarm_i[6] & cfg_i[`TCDI_B_J2_Q]);
		s_nxt = s_r;
		// sample each 500 us, sticky until the 38 ms frame uses it
		if (mf_tick_i && any_alarm) begin
			s_nxt.lat = 1'b1;
		end
		rdi_now = en & (ctrl_i[`TCDI_B_FRC_RDI] |
			(ctrl_i[`TCDI_B_AUTO_RDI] & (s_r.lat | any_alarm)));
		odi_now = en & (ctrl_i[`TCDI_B_FRC_ODI] |
			(ctrl_i[`TCDI_B_AUTO_ODI] & (s_r.lat | any_alarm)));
		if (tcmf_tick_i) begin
			s_nxt.rdi = rdi_now;
			s_nxt.odi = odi_now;
			// live alarm re-latches so nothing is lost on the boundary
			s_nxt.lat = mf_tick_i & any_alarm;
		end
		s_nxt.n2 = {bip2_i, 6'h00};
		if (en) begin
			s_nxt.n2[4] = ctrl_i[`TCDI_B_TC_AIS];
		end // else bits 3..8 stay zero
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign n2_o = s_r.n2;
	assign rdi_bit_o = s_r.rdi;
	assign odi_bit_o = s_r.odi;
	assign rx_tc_alarm_en_o = en;
	assign latch_o = {s_r.lat, any_alarm};
endmodule
`default_nettype wire

// >>> tcdi_top.sv
// Purpose: four-port tandem defect inserter with Wishbone registers
// Assumes: classic Wishbone, 8-bit data in low byte of 32-bit word
// Notes: ack one cycle after stb, unmapped reads give zero
`timescale 1ns/1ps
`include "tcdi_map.svh"
`default_nettype none
module tcdi_top #(
	parameter int MF_CYCLES = `TCDI_MF_CYC,
	parameter int TCMF_MFS = `TCDI_TCMF_MFS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [9:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire tcdi_pkg::tcdi_alarm_t alarm_i [4],
	input wire logic [1:0] bip2_i [4],
	output logic [7:0] n2_o [4],
	output logic [3:0] rdi_bit_o,
	output logic [3:0] odi_bit_o,
	output logic [3:0] rx_tc_alarm_en_o
);
	import tcdi_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		tcdi_byte_t [3:0] ctrl;
		tcdi_byte_t [3:0] cfg;
	} tcdi_top_st_t;
	tcdi_top_st_t s_r;
	tcdi_top_st_t s_nxt;
	logic mf_tick;
	logic tcmf_tick;
	logic [1:0] lat [4];
	logic [7:0] idx;

	localparam logic [7:0] CTRL_A [4] = '{`TCDI_CTRL_P1, `TCDI_CTRL_P2,
		`TCDI_CTRL_P3, `TCDI_CTRL_P4};
	localparam logic [7:0] CFG_A [4] = '{`TCDI_CFG_P1, `TCDI_CFG_P2,
		`TCDI_CFG_P3, `TCDI_CFG_P4};
	localparam logic [7:0] STAT_A [4] = '{`TCDI_STAT_P1, `TCDI_STAT_P2,
		`TCDI_STAT_P3, `TCDI_STAT_P4};

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	tcdi_div #(.CYCLES(MF_CYCLES)) u_mf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(1'b1),
		.tick_o(mf_tick)
	);
	// 76 multiframes per tandem multiframe
	tcdi_div #(.CYCLES(TCMF_MFS)) u_tcmf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(mf_tick),
		.tick_o(tcmf_tick)
	);

	// ----------------------------------------
	// ports
	// ----------------------------------------
	for (genvar p = 0; p < 4; p++) begin : g_port
		tcdi_port u_port (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.ctrl_i(s_r.ctrl[p]),
			.cfg_i(s_r.cfg[p]),
			.alarm_i(alarm_i[p]),
			.mf_tick_i(mf_tick),
			.tcmf_tick_i(tcmf_tick),
			.bip2_i(bip2_i[p]),
			.n2_o(n2_o[p]),
			.rdi_bit_o(rdi_bit_o[p]),
			.odi_bit_o(odi_bit_o[p]),
			.rx_tc_alarm_en_o(rx_tc_alarm_en_o[p]),
			.latch_o(lat[p])
		);
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	always_comb begin
		idx = adr_i[9:2];
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		if (cyc_i && stb_i && !s_r.ack) begin
			s_nxt.ack = 1'b1;
			s_nxt.dat = 32'h0;
			for (int p = 0; p < 4; p++) begin
				if (idx == CTRL_A[p]) begin
					s_nxt.dat[7:0] = s_r.ctrl[p];
					if (we_i && sel_i[0]) begin
						s_nxt.ctrl[p] = dat_i[7:0];
					end
				end
				if (idx == CFG_A[p]) begin
					s_nxt.dat[7:0] = s_r.cfg[p];
					if (we_i && sel_i[0]) begin
						s_nxt.cfg[p] = dat_i[7:0];
					end
				end
				if (idx == STAT_A[p]) begin
					s_nxt.dat[3:0] = {lat[p], rdi_bit_o[p], odi_bit_o[p]};
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r.ack <= 1'b0;
			s_r.dat <= 32'h0;
			s_r.ctrl <= {4{`TCDI_CTRL_RESET}};
			s_r.cfg <= {4{`TCDI_CFG_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ack_o = s_r.ack;
	assign dat_o = s_r.dat;
endmodule
`default_nettype wire

// >>> tcdi_properties.sv
// Purpose: port checks for tcdi_top
// Assumes: one clock, sync reset
// Notes: overhead checks watch port 0
`timescale 1ns/1ps
`default_nettype none
module tcdi_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [7:0] n2_o [4],
	input wire logic [1:0] bip2_i [4],
	input wire logic [3:0] rdi_bit_o,
	input wire logic [3:0] odi_bit_o,
	input wire logic [3:0] rx_tc_alarm_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s; cyc_i && stb_i && !ack_o; endsequence
	sequence ack_s; ack_o ##1 !ack_o; endsequence
	ack_time_a: assert property (req_s |=> ack_s)
		else $error("ack late");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack unasked");
	rd_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
		else $error("read upper set");
	n2_spare_a: assert property (
		n2_o[0][5:0] == {1'b0, n2_o[0][4], 4'h0}) else $error("n2 spare set");
	// n2 is registered, so it trails the enable by one cycle
	n2_off_a: assert property (!rx_tc_alarm_en_o[0] |=>
		n2_o[0][5:0] == 6'h00) else $error("n2 set while off");
	// reset leaves n2 at zero, so skip the first edge after it
	n2_bip_a: assert property (!$past(rst_i) |->
		n2_o[0][7:6] == $past(bip2_i[0])) else $error("n2 bip lost");
	// ais may trail the enable by one cycle
	n2_ais_a: assert property (n2_o[0][4] |-> rx_tc_alarm_en_o[0] ||
		$past(rx_tc_alarm_en_o[0])) else $error("ais while off");
	rdi_en_a: assert property ($rose(rdi_bit_o[0]) |->
		rx_tc_alarm_en_o[0] || $past(rx_tc_alarm_en_o[0]))
		else $error("rdi while off");
	odi_en_a: assert property ($rose(odi_bit_o[0]) |->
		rx_tc_alarm_en_o[0] || $past(rx_tc_alarm_en_o[0]))
		else $error("odi while off");
	rdi_hold_a: assert property ($changed(rdi_bit_o) |=>
		$stable(rdi_bit_o) [*8]) else $error("rdi moved early");
	odi_hold_a: assert property ($changed(odi_bit_o) |=>
		$stable(odi_bit_o) [*8]) else $error("odi moved early");
endmodule
bind tcdi_top tcdi_properties prop_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .n2_o(n2_o),
	.bip2_i(bip2_i),
	.rdi_bit_o(rdi_bit_o), .odi_bit_o(odi_bit_o),
	.rx_tc_alarm_en_o(rx_tc_alarm_en_o));
`default_nettype wire

// >>> tcdi_bus_model.sv
// Purpose: drop side alarms and bip2 source
// Assumes: alarms are levels on clk_i
// Notes: bip2 moves every cycle so stale copies show
`timescale 1ns/1ps
`default_nettype none
module tcdi_bus_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire tcdi_pkg::tcdi_alarm_t req_i [4],
	output tcdi_pkg::tcdi_alarm_t alarm_o [4],
	output logic [1:0] bip2_o [4]
);
	import tcdi_pkg::*;
	logic [1:0] cnt_r;
	always_ff @(posedge clk_i) begin
		cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
		alarm_o <= req_i;
	end
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			bip2_o[p] = cnt_r + 2'(p);
		end
	end
endmodule
`default_nettype wire

// >>> tcdi_top_tb.sv
// Purpose: bench for tcdi_top
// Assumes: tick every 32 cycles (8 x 4)
// Notes: waits poll with bounds
`timescale 1ns/1ps
`include "tcdi_map.svh"
`default_nettype none
module tcdi_top_tb;
	import tcdi_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0] adr_i = 10'h000;
	logic [3:0] sel_i = 4'hF, sel_w = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o;
	logic [3:0] rdi_bit_o, odi_bit_o, rx_tc_alarm_en_o;
	tcdi_alarm_t req [4] = '{default: 11'h000};
	tcdi_alarm_t alarm_i [4];
	logic [1:0] bip2_i [4];
	logic [7:0] n2_o [4];
	int bad_count = 0, samples_checked = 0;
	logic [7:0] ctl [4] = '{8'h51, 8'h81, 8'hB1, 8'hE1};
	tcdi_top #(.MF_CYCLES(8), .TCMF_MFS(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .alarm_i(alarm_i),
		.bip2_i(bip2_i), .n2_o(n2_o), .rdi_bit_o(rdi_bit_o),
		.odi_bit_o(odi_bit_o), .rx_tc_alarm_en_o(rx_tc_alarm_en_o));
	tcdi_bus_model far (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.alarm_o(alarm_i), .bip2_o(bip2_i));
	initial forever #12.5 clk_i = ~clk_i;
	task automatic chk(input string what, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %0h got %0h", what, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] idx, d);
		int n = 0;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		sel_i <= sel_w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rd = dat_o;
		chk("ack", 1, ack_o);
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic waitv(string what, ref logic [3:0] s, input int p, logic v);
		for (int n = 0; n < 80 && s[p] !== v; n++) @(posedge clk_i);
		chk(what, v, s[p]);
	endtask
	task automatic print_verdict();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			wb(0, ctl[i], 0);
			chk("ctrl reset", 0, rd);
			wb(1, ctl[i], 8'hE0 | 8'(i));
		end
		for (int i = 0; i < 4; i++) begin
			wb(0, ctl[i], 0);
			chk("ctrl", 8'hE0 | 8'(i), rd);
		end
		wb(0, 8'h10, 0);
		chk("unmapped", 0, rd);
		// a write without the low byte lane must leave the register alone
		sel_w = 4'hE;
		wb(1, ctl[3], 8'h5A);
		sel_w = 4'hF;
		wb(0, ctl[3], 0);
		chk("sel gate", 8'hE3, rd);
	endtask
	task automatic t_n2();
		for (int i = 0; i < 4; i++) begin
			wb(1, ctl[i], 8'h30);
			chk("n2 ais", 8'h10, n2_o[i][5:0]);
			chk("rx en", 4'h1 << i, rx_tc_alarm_en_o);
			wb(1, ctl[i], 8'hE0);
			chk("n2 off", 0, n2_o[i][5:0]);
			chk("rx off", 0, rx_tc_alarm_en_o);
		end
	endtask
	task automatic t_force();
		wb(1, ctl[0], 8'hD0);
		waitv("rdi", rdi_bit_o, 0, 1);
		waitv("odi", odi_bit_o, 0, 1);
		chk("others", 0, rdi_bit_o[3:1]);
		wb(1, ctl[0], 8'hC0);
		waitv("rdi off", rdi_bit_o, 0, 0);
		wb(1, ctl[0], 8'h10);
		req[0] <= 11'h001;
		repeat (70) @(posedge clk_i);
		chk("no auto", 0, rdi_bit_o[0]);
		req[0] <= 11'h000;
	endtask
	task automatic t_auto();
		int ua [7] = '{0, 1, 5, 7, 8, 9, 10};
		wb(1, ctl[1], 8'h1C);
		foreach (ua[k]) begin
			req[1][ua[k]] <= 1;
			repeat (10) @(posedge clk_i);
			req[1][ua[k]] <= 0;
			waitv("auto rdi", rdi_bit_o, 1, 1);
			waitv("auto odi", odi_bit_o, 1, 1);
			waitv("rdi clear", rdi_bit_o, 1, 0);
		end
	endtask
	task automatic t_qual();
		int qa [4] = '{2, 3, 4, 6};
		wb(1, ctl[2], 8'h1C);
		foreach (qa[k]) begin
			req[2][qa[k]] <= 1;
			repeat (70) @(posedge clk_i);
			chk("unqualified", 0, rdi_bit_o[2]);
			wb(1, ctl[2] + 8'h02, 8'h02 << k);
			waitv("qualified", rdi_bit_o, 2, 1);
			wb(0, ctl[2] + 8'h03, 0);
			chk("status", 8'h0F, rd);
			req[2][qa[k]] <= 0;
			wb(1, ctl[2] + 8'h02, 0);
			waitv("q clear", rdi_bit_o, 2, 0);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		t_regs();
		t_n2();
		t_force();
		t_auto();
		t_qual();
		print_verdict();
	end
	initial begin
		#500000;
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
